// [rtl/iorb_consts.svh]
// Offsets, field masks, reset values and address limits of the low I/O register bank
`ifndef IORB_CONSTS_SVH
`define IORB_CONSTS_SVH

// I/O offsets within the bit-addressable window
`define IORB_OFF_POWER_REDUCTION 5'h00
`define IORB_OFF_DIGITAL_INPUT_DISABLE 5'h01
`define IORB_OFF_CONVERTER_CONTROL_B 5'h03
`define IORB_OFF_CONVERTER_RESULT_LOW 5'h04
`define IORB_OFF_CONVERTER_RESULT_HIGH 5'h05
`define IORB_OFF_CONVERTER_CONTROL_STATUS_A 5'h06
`define IORB_OFF_CONVERTER_CHANNEL_SELECT 5'h07
`define IORB_OFF_COMPARATOR_CONTROL_STATUS 5'h08
`define IORB_OFF_TIMER1_FLAGS 5'h0b
`define IORB_OFF_TIMER1_IRQ_MASK 5'h0c
`define IORB_OFF_SERIAL_IFACE_CONTROL 5'h0d
`define IORB_OFF_SERIAL_IFACE_STATUS 5'h0e
`define IORB_OFF_SERIAL_IFACE_SHIFT_DATA 5'h0f
`define IORB_OFF_SERIAL_IFACE_BUFFER 5'h10
`define IORB_OFF_PIN_CHANGE_MASK_LOW 5'h12
`define IORB_OFF_SCRATCH_REG_0 5'h13
`define IORB_OFF_SCRATCH_REG_1 5'h14
`define IORB_OFF_SCRATCH_REG_2 5'h15
`define IORB_OFF_PORT_B_INPUT 5'h16
`define IORB_OFF_PORT_B_DIRECTION 5'h17
`define IORB_OFF_PORT_B_OUTPUT 5'h18

// Writable bit masks; reserved bits stay zero
`define IORB_RW_POWER_REDUCTION 8'hef
`define IORB_RW_DIGITAL_INPUT_DISABLE 8'h3f
`define IORB_RW_CONVERTER_CONTROL_B 8'hd7
`define IORB_RW_CONVERTER_CONTROL_STATUS_A 8'hef
`define IORB_RW_CONVERTER_CHANNEL_SELECT 8'h47
`define IORB_RW_COMPARATOR_CONTROL_STATUS 8'hcb
`define IORB_RW_TIMER1_IRQ_MASK 8'h07
`define IORB_RW_SERIAL_IFACE_STATUS 8'h0f
`define IORB_RW_FULL 8'hff

// Write-one-to-clear flag masks
`define IORB_W1C_CONVERTER_DONE 8'h10
`define IORB_W1C_COMPARATOR_EVENT 8'h10
`define IORB_W1C_TIMER1_FLAGS 8'h07
`define IORB_W1C_SERIAL_IFACE_STATUS 8'he0

// Read-only and flag field positions inside mixed registers
`define IORB_POS_COMPARATOR_LEVEL 5
`define IORB_POS_SERIAL_BUSY 4
`define IORB_POS_CONVERTER_DONE 4
`define IORB_POS_COMPARATOR_EVENT 4

// Reset value and address windows
`define IORB_RST_VAL 8'h00
`define IORB_BIT_SPAN 32
`define IORB_DATA_ALIAS 7'h20
`define IORB_IO_TOP 7'h1f
`define IORB_ALIAS_TOP 7'h3f

`endif

// [rtl/iorb_pkg.sv]
// Types shared by the low I/O register bank
package iorb_pkg;
	typedef logic [7:0] iorb_byte_type;

	// Access kinds issued by the core
	typedef enum logic [2:0]
	{
		IORB_OP_NONE = 3'h0,
		IORB_OP_READ = 3'h1,
		IORB_OP_WRITE = 3'h2,
		IORB_OP_SET_BIT = 3'h3,
		IORB_OP_CLEAR_BIT = 3'h4,
		IORB_OP_TEST_BIT = 3'h5
	} iorb_op_type;
endpackage

// [rtl/iorb_sync.sv]
// Two-flop synchroniser for pin inputs
module iorb_sync #(
	parameter int WIDTH = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("iorb_sync needs WIDTH of at least one");
	end

	// First stage feeds only the second
	always_comb
	begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;
endmodule

// [rtl/iorb_regbank.sv]
// Low I/O register bank with byte, bit and data-space access for the core
// What this block does
// - Addresses 0x00 to 0x1F accept single-bit set and clear; bit operations elsewhere are refused.
// - Bit test on those addresses reports the bit and whether the next instruction is skipped.
// - Status flags clear when a one is written to them and keep their value when zero is written.
// - A single-bit set or clear changes only the addressed bit, leaving other flags pending.
`include "iorb_consts.svh"

module iorb_regbank #(
	parameter int ADDR_W = 7
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [2:0] i_op,
	input wire logic i_data_space,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_wdata,
	input wire logic i_skip_if_set,
	input wire logic [15:0] i_conv_result,
	input wire logic i_conv_done,
	input wire logic i_comp_level,
	input wire logic i_comp_event,
	input wire logic [2:0] i_timer1_event,
	input wire logic [2:0] i_serial_event,
	input wire logic i_serial_busy,
	input wire logic [7:0] i_serial_buffer,
	input wire logic [7:0] i_port_b_pins,
	output logic [7:0] o_rdata,
	output logic o_bit_value,
	output logic o_skip,
	output logic o_bit_refused,
	output logic [7:0] o_power_reduction,
	output logic [7:0] o_digital_input_disable,
	output logic [7:0] o_converter_control_b,
	output logic [7:0] o_converter_control_status_a,
	output logic [7:0] o_converter_channel_select,
	output logic [7:0] o_comparator_control_status,
	output logic [7:0] o_timer1_irq_mask,
	output logic [7:0] o_serial_iface_control,
	output logic [7:0] o_serial_iface_status,
	output logic [7:0] o_serial_iface_shift_data,
	output logic [7:0] o_pin_change_mask_low,
	output logic [7:0] o_port_b_direction,
	output logic [7:0] o_port_b_output
);
	localparam int SPAN = `IORB_BIT_SPAN;

	iorb_pkg::iorb_byte_type reg_q [SPAN];
	iorb_pkg::iorb_byte_type reg_d [SPAN];
	iorb_pkg::iorb_byte_type ro_val [SPAN];
	iorb_pkg::iorb_byte_type ev_set [SPAN];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic bit_value_q;
	logic bit_value_d;
	logic skip_q;
	logic skip_d;
	logic refused_q;
	logic refused_d;
	logic [7:0] pins_sync;
	logic hit;
	logic [4:0] idx;
	logic io_bit_ok;
	iorb_pkg::iorb_op_type op;

	if (ADDR_W < 7)
	begin : g_bad_addr
		$error("iorb_regbank needs ADDR_W of at least 7 to see the data-space alias");
	end

	// Bits that software may store
	function automatic logic [7:0] rw_mask(input logic [4:0] a);
		case (a)
			`IORB_OFF_POWER_REDUCTION: rw_mask = `IORB_RW_POWER_REDUCTION;
			`IORB_OFF_DIGITAL_INPUT_DISABLE: rw_mask = `IORB_RW_DIGITAL_INPUT_DISABLE;
			`IORB_OFF_CONVERTER_CONTROL_B: rw_mask = `IORB_RW_CONVERTER_CONTROL_B;
			`IORB_OFF_CONVERTER_CONTROL_STATUS_A: rw_mask = `IORB_RW_CONVERTER_CONTROL_STATUS_A;
			`IORB_OFF_CONVERTER_CHANNEL_SELECT: rw_mask = `IORB_RW_CONVERTER_CHANNEL_SELECT;
			`IORB_OFF_COMPARATOR_CONTROL_STATUS: rw_mask = `IORB_RW_COMPARATOR_CONTROL_STATUS;
			`IORB_OFF_TIMER1_IRQ_MASK: rw_mask = `IORB_RW_TIMER1_IRQ_MASK;
			`IORB_OFF_SERIAL_IFACE_STATUS: rw_mask = `IORB_RW_SERIAL_IFACE_STATUS;
			`IORB_OFF_SERIAL_IFACE_CONTROL,
			`IORB_OFF_SERIAL_IFACE_SHIFT_DATA,
			`IORB_OFF_PIN_CHANGE_MASK_LOW,
			`IORB_OFF_SCRATCH_REG_0,
			`IORB_OFF_SCRATCH_REG_1,
			`IORB_OFF_SCRATCH_REG_2,
			`IORB_OFF_PORT_B_DIRECTION,
			`IORB_OFF_PORT_B_OUTPUT: rw_mask = `IORB_RW_FULL;
			default: rw_mask = 8'h00;
		endcase
	endfunction

	// Flags that hardware sets and a written one clears
	function automatic logic [7:0] w1c_mask(input logic [4:0] a);
		case (a)
			`IORB_OFF_CONVERTER_CONTROL_STATUS_A: w1c_mask = `IORB_W1C_CONVERTER_DONE;
			`IORB_OFF_COMPARATOR_CONTROL_STATUS: w1c_mask = `IORB_W1C_COMPARATOR_EVENT;
			`IORB_OFF_TIMER1_FLAGS: w1c_mask = `IORB_W1C_TIMER1_FLAGS;
			`IORB_OFF_SERIAL_IFACE_STATUS: w1c_mask = `IORB_W1C_SERIAL_IFACE_STATUS;
			default: w1c_mask = 8'h00;
		endcase
	endfunction

	// Port pins come from outside the clock domain
	iorb_sync #(
		.WIDTH(8)
	) u_pin_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_port_b_pins),
		.o_sync(pins_sync)
	);

	// Address decode: I/O window direct, data window shifted down
	always_comb
	begin
		op = iorb_pkg::iorb_op_type'(i_op);
		hit = 1'b0;
		idx = i_addr[4:0];
		if (!i_data_space)
		begin
			hit = (i_addr <= ADDR_W'(`IORB_IO_TOP));
		end
		else
		begin
			hit = (i_addr >= ADDR_W'(`IORB_DATA_ALIAS)) && (i_addr <= ADDR_W'(`IORB_ALIAS_TOP));
		end
		io_bit_ok = hit && !i_data_space;
	end

	// Live read-only fields and hardware flag events per address
	always_comb
	begin
		for (int a = 0; a < SPAN; a++)
		begin
			ro_val[a] = 8'h00;
			ev_set[a] = 8'h00;
		end
		ro_val[`IORB_OFF_CONVERTER_RESULT_LOW] = i_conv_result[7:0];
		ro_val[`IORB_OFF_CONVERTER_RESULT_HIGH] = i_conv_result[15:8];
		ro_val[`IORB_OFF_COMPARATOR_CONTROL_STATUS][`IORB_POS_COMPARATOR_LEVEL] = i_comp_level;
		ro_val[`IORB_OFF_SERIAL_IFACE_STATUS][`IORB_POS_SERIAL_BUSY] = i_serial_busy;
		ro_val[`IORB_OFF_SERIAL_IFACE_BUFFER] = i_serial_buffer;
		ro_val[`IORB_OFF_PORT_B_INPUT] = pins_sync;
		ev_set[`IORB_OFF_CONVERTER_CONTROL_STATUS_A][`IORB_POS_CONVERTER_DONE] = i_conv_done;
		ev_set[`IORB_OFF_COMPARATOR_CONTROL_STATUS][`IORB_POS_COMPARATOR_EVENT] = i_comp_event;
		ev_set[`IORB_OFF_TIMER1_FLAGS][2:0] = i_timer1_event;
		ev_set[`IORB_OFF_SERIAL_IFACE_STATUS][7:5] = i_serial_event;
	end

	// Register next values; hardware set is applied last so it beats a clear
	always_comb
	begin
		logic [7:0] rw;
		logic [7:0] fc;
		rw = 8'h00;
		fc = 8'h00;
		for (int a = 0; a < SPAN; a++)
		begin
			rw = rw_mask(5'(a));
			fc = w1c_mask(5'(a));
			reg_d[a] = reg_q[a];
			if (hit && idx == 5'(a) && op == iorb_pkg::IORB_OP_WRITE)
			begin
				reg_d[a] = (reg_q[a] & ~rw) | (i_wdata & rw);
				reg_d[a] = reg_d[a] & ~(i_wdata & fc);
			end
			if (io_bit_ok && idx == 5'(a) && op == iorb_pkg::IORB_OP_SET_BIT)
			begin
				// Only the selected bit moves; sibling flags are untouched
				if (rw[i_bit_sel])
					reg_d[a][i_bit_sel] = 1'b1;
				if (fc[i_bit_sel])
					reg_d[a][i_bit_sel] = 1'b0;
			end
			if (io_bit_ok && idx == 5'(a) && op == iorb_pkg::IORB_OP_CLEAR_BIT)
			begin
				// Writing zero to a flag leaves it alone
				if (rw[i_bit_sel])
					reg_d[a][i_bit_sel] = 1'b0;
			end
			reg_d[a] = (reg_d[a] | (ev_set[a] & fc)) & (rw | fc);
		end
	end

	// Read data, bit test and refusal; readback merges stored and live bits
	always_comb
	begin
		logic [7:0] view;
		view = (reg_q[idx] & (rw_mask(idx) | w1c_mask(idx))) | ro_val[idx];
		rdata_d = rdata_q;
		bit_value_d = bit_value_q;
		skip_d = 1'b0;
		refused_d = 1'b0;
		case (op)
			iorb_pkg::IORB_OP_READ:
			begin
				rdata_d = hit ? view : 8'h00;
			end
			iorb_pkg::IORB_OP_TEST_BIT:
			begin
				if (io_bit_ok)
				begin
					bit_value_d = view[i_bit_sel];
					skip_d = (view[i_bit_sel] == i_skip_if_set);
				end
				else
				begin
					refused_d = 1'b1;
				end
			end
			iorb_pkg::IORB_OP_SET_BIT,
			iorb_pkg::IORB_OP_CLEAR_BIT:
			begin
				refused_d = !io_bit_ok;
			end
			default:
			begin
				refused_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			for (int a = 0; a < SPAN; a++)
				reg_q[a] <= `IORB_RST_VAL;
			rdata_q <= 8'h00;
			bit_value_q <= 1'b0;
			skip_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			for (int a = 0; a < SPAN; a++)
				reg_q[a] <= reg_d[a];
			rdata_q <= rdata_d;
			bit_value_q <= bit_value_d;
			skip_q <= skip_d;
			refused_q <= refused_d;
		end
	end

	// Core answers and peripheral controls straight from flops
	assign o_rdata = rdata_q;
	assign o_bit_value = bit_value_q;
	assign o_skip = skip_q;
	assign o_bit_refused = refused_q;
	assign o_power_reduction = reg_q[`IORB_OFF_POWER_REDUCTION];
	assign o_digital_input_disable = reg_q[`IORB_OFF_DIGITAL_INPUT_DISABLE];
	assign o_converter_control_b = reg_q[`IORB_OFF_CONVERTER_CONTROL_B];
	assign o_converter_control_status_a = reg_q[`IORB_OFF_CONVERTER_CONTROL_STATUS_A];
	assign o_converter_channel_select = reg_q[`IORB_OFF_CONVERTER_CHANNEL_SELECT];
	assign o_comparator_control_status = reg_q[`IORB_OFF_COMPARATOR_CONTROL_STATUS];
	assign o_timer1_irq_mask = reg_q[`IORB_OFF_TIMER1_IRQ_MASK];
	assign o_serial_iface_control = reg_q[`IORB_OFF_SERIAL_IFACE_CONTROL];
	assign o_serial_iface_status = reg_q[`IORB_OFF_SERIAL_IFACE_STATUS];
	assign o_serial_iface_shift_data = reg_q[`IORB_OFF_SERIAL_IFACE_SHIFT_DATA];
	assign o_pin_change_mask_low = reg_q[`IORB_OFF_PIN_CHANGE_MASK_LOW];
	assign o_port_b_direction = reg_q[`IORB_OFF_PORT_B_DIRECTION];
	assign o_port_b_output = reg_q[`IORB_OFF_PORT_B_OUTPUT];
endmodule

// [sim/iorb_regbank_checker.sv]
// Port-level assertions for the low I/O register bank
module iorb_regbank_checker #(
	parameter int ADDR_W = 7
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [2:0] i_op,
	input wire logic i_data_space,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_wdata,
	input wire logic i_skip_if_set,
	input wire logic [2:0] i_serial_event,
	input wire logic o_bit_value,
	input wire logic o_skip,
	input wire logic o_bit_refused,
	input wire logic [7:0] o_serial_iface_status,
	input wire logic [7:0] o_port_b_direction,
	input wire logic [7:0] o_port_b_output
);
	timeunit 1ns;
	timeprecision 100ps;
	// Bit ops are honoured only in I/O space below 0x20
	logic bit_op;
	logic io_low;
	assign bit_op = (i_op >= 3'h3) && (i_op <= 3'h5);
	assign io_low = !i_data_space && (i_addr < 32);

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	a_refuse_outside: assert property (bit_op && !io_low |=> o_bit_refused)
		else $error("bit op outside low window not refused");
	a_accept_inside: assert property (bit_op && io_low |=> !o_bit_refused)
		else $error("bit op inside low window refused");
	a_set_one_bit: assert property (i_op == 3'h3 && io_low && i_addr == 'h18 |=>
		o_port_b_output == ($past(o_port_b_output) | (8'h01 << $past(i_bit_sel))))
		else $error("set bit touched more than one bit");
	a_clear_one_bit: assert property (i_op == 3'h4 && io_low && i_addr == 'h17 |=>
		o_port_b_direction == ($past(o_port_b_direction) & ~(8'h01 << $past(i_bit_sel))))
		else $error("clear bit touched more than one bit");
	a_alias_write: assert property (i_op == 3'h2 && i_addr == (i_data_space ? 'h37 : 'h17) |=>
		o_port_b_direction == $past(i_wdata))
		else $error("direction write lost");
	a_skip_polarity: assert property (i_op == 3'h5 && io_low && i_addr == 'h18 |=>
		o_bit_value == $past(o_port_b_output[i_bit_sel]) &&
		o_skip == (o_bit_value == $past(i_skip_if_set)))
		else $error("bit test result wrong");
	a_skip_cause: assert property (o_skip |-> $past(i_op) == 3'h5)
		else $error("skip without bit test");
	a_refused_quiet: assert property (o_bit_refused |->
		$stable(o_port_b_output) && $stable(o_port_b_direction))
		else $error("refused op changed a register");
	a_flag_bit_clear: assert property (i_op == 3'h3 && io_low && i_addr == 'h0e &&
		i_bit_sel >= 3'h5 && i_serial_event == 3'h0 |=>
		o_serial_iface_status == ($past(o_serial_iface_status) & ~(8'h01 << $past(i_bit_sel))))
		else $error("flag set bit disturbed other bits");

	c_refused: cover property (bit_op && !io_low);
	c_skip: cover property (o_skip);
	c_flag_set_bit: cover property (i_op == 3'h3 && i_addr == 'h0e);
endmodule

bind iorb_regbank iorb_regbank_checker #(.ADDR_W(ADDR_W)) chk_u (.i_clk_sys, .i_rst_n, .i_op,
	.i_data_space, .i_addr, .i_bit_sel, .i_wdata, .i_skip_if_set, .i_serial_event, .o_bit_value,
	.o_skip, .o_bit_refused, .o_serial_iface_status, .o_port_b_direction, .o_port_b_output);

// [sim/iorb_core_model.sv]
// Behavioural core issuing byte and bit accesses to the register bank
module iorb_core_model (
	input wire logic i_clk_sys,
	output logic [2:0] o_op,
	output logic o_data_space,
	output logic [6:0] o_addr,
	output logic [2:0] o_bit_sel,
	output logic [7:0] o_wdata,
	output logic o_skip_if_set
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		{o_op, o_data_space, o_addr, o_bit_sel, o_wdata, o_skip_if_set} = '0;
	end

	// One access, held over the taking edge; once released, op drops to none and address and write data are inverted
	task automatic access(input logic [2:0] op, input logic ds, input logic [6:0] addr,
		input logic [2:0] sel, input logic [7:0] wd, input logic pol);
		logic [6:0] io;
		io = ds ? addr - 7'h20 : addr;
		@(negedge i_clk_sys);
		// Writes to reserved I/O addresses 0x02, 0x09, 0x0A, 0x11 and 0x1F are never issued
		o_op = (op == 3'h2 && io inside {7'h02, 7'h09, 7'h0a, 7'h11, 7'h1f}) ? 3'h0 : op;
		{o_data_space, o_addr, o_bit_sel, o_wdata, o_skip_if_set} = {ds, addr, sel, wd, pol};
		@(negedge i_clk_sys);
		o_op = 3'h0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
endmodule

// [sim/iorb_regbank_tb.sv]
// Self-checking bench for the low I/O register bank
module iorb_regbank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk_sys;
	logic i_rst_n;
	logic [2:0] op;
	logic ds;
	logic [6:0] addr;
	logic [2:0] sel;
	logic [7:0] wd;
	logic pol;
	logic [2:0] sev;
	logic [2:0] tev;
	logic [7:0] pins;
	logic [15:0] conv;
	logic [7:0] sbuf;
	logic [7:0] rdata;
	logic bval;
	logic skip;
	logic refused;
	logic [7:0] sstat;
	logic [7:0] tmask;
	logic [7:0] dir;
	logic [7:0] pout;
	int num_errors;
	int check_count;

	iorb_core_model core_u (.i_clk_sys(i_clk_sys), .o_op(op), .o_data_space(ds), .o_addr(addr),
		.o_bit_sel(sel), .o_wdata(wd), .o_skip_if_set(pol));
	iorb_regbank #(.ADDR_W(7)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_op(op),
		.i_data_space(ds), .i_addr(addr), .i_bit_sel(sel), .i_wdata(wd), .i_skip_if_set(pol),
		.i_conv_result(conv), .i_conv_done(1'b0), .i_comp_level(1'b0), .i_comp_event(1'b0),
		.i_timer1_event(tev), .i_serial_event(sev), .i_serial_busy(1'b0),
		.i_serial_buffer(sbuf), .i_port_b_pins(pins), .o_rdata(rdata), .o_bit_value(bval),
		.o_skip(skip), .o_bit_refused(refused), .o_power_reduction(),
		.o_digital_input_disable(), .o_converter_control_b(), .o_converter_control_status_a(),
		.o_converter_channel_select(), .o_comparator_control_status(), .o_timer1_irq_mask(tmask),
		.o_serial_iface_control(), .o_serial_iface_status(sstat), .o_serial_iface_shift_data(),
		.o_pin_change_mask_low(), .o_port_b_direction(dir), .o_port_b_output(pout));

	// Free-running 40 MHz clock
	initial
	begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Read through the core and compare the returned byte
	task automatic rd(input string name, input logic d, input logic [6:0] a, input logic [7:0] e);
		core_u.access(3'h1, d, a, 3'h0, 8'h00, 1'b0);
		chk8(name, e, rdata);
	endtask

	task automatic t_reset();
		chk8("dir", 8'h00, dir);
		chk8("pout", 8'h00, pout);
		chk8("sstat", 8'h00, sstat);
		chk8("rdata", 8'h00, rdata);
		$display("reset test done");
	endtask

	task automatic t_alias();
		core_u.access(3'h2, 1'b0, 7'h17, 3'h0, 8'ha5, 1'b0);
		rd("dir alias", 1'b1, 7'h37, 8'ha5);
		core_u.access(3'h2, 1'b1, 7'h33, 3'h0, 8'h5a, 1'b0);
		rd("scratch io", 1'b0, 7'h13, 8'h5a);
		$display("alias test done");
	endtask

	task automatic t_bits();
		core_u.access(3'h2, 1'b0, 7'h18, 3'h0, 8'h81, 1'b0);
		core_u.access(3'h3, 1'b0, 7'h18, 3'h2, 8'h00, 1'b0);
		chk8("pout set", 8'h85, pout);
		core_u.access(3'h4, 1'b0, 7'h18, 3'h7, 8'h00, 1'b0);
		chk8("pout clr", 8'h05, pout);
		core_u.access(3'h4, 1'b0, 7'h17, 3'h0, 8'h00, 1'b0);
		chk8("dir clr", 8'ha4, dir);
		core_u.access(3'h3, 1'b1, 7'h38, 3'h3, 8'h00, 1'b0);
		chk8("data refused", 8'h01, {7'h00, refused});
		chk8("pout kept", 8'h05, pout);
		for (int k = 3; k <= 5; k++)
		begin
			core_u.access(k[2:0], 1'b0, 7'h20, 3'h0, 8'h00, 1'b0);
			chk8("high refused", 8'h01, {7'h00, refused});
		end
		$display("bit access test done");
	endtask

	task automatic t_skip();
		for (int b = 0; b < 2; b++)
			for (int p = 0; p < 2; p++)
			begin
				core_u.access(3'h5, 1'b0, 7'h18, b[2:0], 8'h00, p[0]);
				chk8("bit value", {7'h00, ~b[0]}, {7'h00, bval});
				chk8("skip", {7'h00, ~b[0] == p[0]}, {7'h00, skip});
			end
		$display("skip test done");
	endtask

	task automatic t_flags();
		@(negedge i_clk_sys);
		sev = 3'h7;
		@(negedge i_clk_sys);
		sev = 3'h0;
		chk8("flags up", 8'he0, sstat);
		core_u.access(3'h2, 1'b0, 7'h0e, 3'h0, 8'h20, 1'b0);
		chk8("w1c one", 8'hc0, sstat);
		core_u.access(3'h2, 1'b0, 7'h0e, 3'h0, 8'h00, 1'b0);
		chk8("w1c zero", 8'hc0, sstat);
		core_u.access(3'h3, 1'b0, 7'h0e, 3'h6, 8'h00, 1'b0);
		chk8("set bit flag", 8'h80, sstat);
		core_u.access(3'h4, 1'b0, 7'h0e, 3'h7, 8'h00, 1'b0);
		chk8("clr bit flag", 8'h80, sstat);
		$display("flag test done");
	endtask

	task automatic t_masks();
		core_u.access(3'h2, 1'b0, 7'h0c, 3'h0, 8'hff, 1'b0);
		chk8("mask bits", 8'h07, tmask);
		core_u.access(3'h2, 1'b0, 7'h10, 3'h0, 8'hff, 1'b0);
		rd("buffer ro", 1'b0, 7'h10, 8'h3c);
		rd("pins", 1'b1, 7'h36, 8'h96);
		rd("conv high", 1'b0, 7'h05, 8'h12);
		rd("unmapped", 1'b0, 7'h02, 8'h00);
		$display("mask test done");
	endtask

	// Timer flags; an event in the clearing cycle must survive the clear
	task automatic t_timer();
		@(negedge i_clk_sys);
		tev = 3'h5;
		@(negedge i_clk_sys);
		tev = 3'h1;
		rd("t1 flags up", 1'b0, 7'h0b, 8'h05);
		core_u.access(3'h2, 1'b0, 7'h0b, 3'h0, 8'h05, 1'b0);
		tev = 3'h0;
		rd("t1 set wins", 1'b0, 7'h0b, 8'h01);
		core_u.access(3'h2, 1'b0, 7'h0b, 3'h0, 8'h01, 1'b0);
		rd("t1 cleared", 1'b0, 7'h0b, 8'h00);
		$display("timer flag test done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reset for 16 cycles, then run every scenario
	initial
	begin
		num_errors = 0;
		check_count = 0;
		i_rst_n = 1'b0;
		sev = 3'h0;
		tev = 3'h0;
		pins = 8'h96;
		conv = 16'h1234;
		sbuf = 8'h3c;
		repeat (16) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		t_reset();
		t_alias();
		t_bits();
		t_skip();
		t_flags();
		t_masks();
		t_timer();
		results();
	end
endmodule
